//--- common/nbi_regs.vh
// constants for the nand bus host controller
`ifndef NBI_REGS_VH
`define NBI_REGS_VH
// ------------------------------------------------------------
// address layout
// ------------------------------------------------------------
`define NBI_ADDR_CYCLES 3'd5
`define NBI_COL_WIDTH 12
`define NBI_ROW_WIDTH 17
`define NBI_PLANE_BIT 6
`define NBI_PAGE_BYTES 12'd2176
`define NBI_PAGES_PER_BLOCK 64
`define NBI_BLOCKS 2048
// ------------------------------------------------------------
// commands
// ------------------------------------------------------------
`define NBI_CMD_READ_SETUP 8'h00
`define NBI_CMD_READ_CONFIRM 8'h30
`define NBI_CMD_PROG_SETUP 8'h80
`define NBI_CMD_PROG_CONFIRM 8'h10
`define NBI_CMD_ERASE_SETUP 8'h60
`define NBI_CMD_ERASE_CONFIRM 8'hd0
// ------------------------------------------------------------
// operation codes on the user port
// ------------------------------------------------------------
`define NBI_OP_READ 2'd0
`define NBI_OP_PROG 2'd1
`define NBI_OP_ERASE 2'd2
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define NBI_STROBE_NS 20
`define NBI_CLK_NS 10
`define NBI_STROBE_CYC ((`NBI_STROBE_NS + `NBI_CLK_NS - 1) / `NBI_CLK_NS)
`define NBI_BUSY_WAIT_NS 200
`define NBI_BUSY_WAIT_CYC ((`NBI_BUSY_WAIT_NS + `NBI_CLK_NS - 1) / `NBI_CLK_NS)
`define NBI_PROG_TYP_NS 250000
`define NBI_ERASE_TYP_NS 2000000
`endif

//--- design/nbi_host.v
// host controller driving a multiplexed nand flash bus
`timescale 1ns/1ps
`default_nettype none
`include "nbi_regs.vh"

module nbi_host (
   // clock and reset
   input wire CLOCK,
   input wire RST,
   // user request
   input wire START,
   input wire [1:0] OP,
   input wire [11:0] COLUMN,
   input wire [16:0] ROW,
   input wire WP_ALLOW,
   output reg READY,
   output reg DONE,
   // user write data
   input wire [7:0] WDATA,
   output reg WDATA_TAKE,
   // user read data
   output reg [7:0] RDATA,
   output reg RDATA_VALID,
   // nand pins
   output reg CE_N,
   output reg CLE,
   output reg ALE,
   output reg WE_N,
   output reg RE_N,
   output reg WP_N,
   output reg [7:0] IO_OUT,
   output reg IO_OE,
   input wire [7:0] IO_IN,
   input wire RB_N
);
// ------------------------------------------------------------
// states
// ------------------------------------------------------------
localparam S_IDLE = 4'd0;
localparam S_CMD1 = 4'd1;
localparam S_ADDR = 4'd2;
localparam S_DATA = 4'd3;
localparam S_CMD2 = 4'd4;
localparam S_WAIT = 4'd5;
localparam S_BUSY = 4'd6;
localparam S_READ = 4'd7;
localparam S_DONE = 4'd8;
localparam integer STROBE_NUM = `NBI_STROBE_CYC;
localparam integer BUSY_WAIT_NUM = `NBI_BUSY_WAIT_CYC;
localparam [3:0] STROBE_CYC = STROBE_NUM[3:0];
localparam [5:0] BUSY_WAIT_CYC = BUSY_WAIT_NUM[5:0];

reg [3:0] state_q;
reg [1:0] op_q;
reg [11:0] col_q;
reg [16:0] row_q;
reg [2:0] acnt_q;
reg [11:0] bcnt_q;
reg [3:0] tcnt_q;
reg [5:0] wcnt_q;
reg phase_q;
reg [7:0] io_s1_q;
reg [7:0] io_s2_q;
reg rb_s1_q;
reg rb_s2_q;

// ------------------------------------------------------------
// helpers
// ------------------------------------------------------------
function [7:0] addr_byte;
   input [2:0] idx;
   input [11:0] col;
   input [16:0] row;
   begin
      case (idx)
         3'd0: addr_byte = col[7:0];
         3'd1: addr_byte = {4'h0, col[11:8]};
         3'd2: addr_byte = row[7:0];
         3'd3: addr_byte = row[15:8];
         default: addr_byte = {7'h00, row[16]};
      endcase
   end
endfunction

function [7:0] first_cmd;
   input [1:0] op;
   begin
      case (op)
         `NBI_OP_PROG: first_cmd = `NBI_CMD_PROG_SETUP;
         `NBI_OP_ERASE: first_cmd = `NBI_CMD_ERASE_SETUP;
         default: first_cmd = `NBI_CMD_READ_SETUP;
      endcase
   end
endfunction

function [7:0] second_cmd;
   input [1:0] op;
   begin
      case (op)
         `NBI_OP_PROG: second_cmd = `NBI_CMD_PROG_CONFIRM;
         `NBI_OP_ERASE: second_cmd = `NBI_CMD_ERASE_CONFIRM;
         default: second_cmd = `NBI_CMD_READ_CONFIRM;
      endcase
   end
endfunction

// ------------------------------------------------------------
// input synchronisers
// ------------------------------------------------------------
always @(posedge CLOCK) begin
   if (RST) begin
      io_s1_q <= 8'h00;
      io_s2_q <= 8'h00;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
   end else begin
      io_s1_q <= IO_IN;
      io_s2_q <= io_s1_q;
      rb_s1_q <= RB_N;
      rb_s2_q <= rb_s1_q;
   end
end

// ------------------------------------------------------------
// sequencer
// ------------------------------------------------------------
// each byte: phase 0 strobe low for STROBE_CYC, phase 1 strobe high for STROBE_CYC
always @(posedge CLOCK) begin
   if (RST) begin
      state_q <= S_IDLE;
      op_q <= 2'd0;
      col_q <= 12'h000;
      row_q <= 17'h00000;
      acnt_q <= 3'd0;
      bcnt_q <= 12'h000;
      tcnt_q <= 4'h0;
      wcnt_q <= 6'h00;
      phase_q <= 1'b0;
      READY <= 1'b0;
      DONE <= 1'b0;
      WDATA_TAKE <= 1'b0;
      RDATA <= 8'h00;
      RDATA_VALID <= 1'b0;
      CE_N <= 1'b1;
      CLE <= 1'b0;
      ALE <= 1'b0;
      WE_N <= 1'b1;
      RE_N <= 1'b1;
      WP_N <= 1'b0;
      IO_OUT <= 8'h00;
      IO_OE <= 1'b0;
   end else begin
      DONE <= 1'b0;
      WDATA_TAKE <= 1'b0;
      RDATA_VALID <= 1'b0;
      case (state_q)
         S_IDLE: begin
            READY <= 1'b1;
            CE_N <= 1'b1;
            IO_OE <= 1'b0;
            WP_N <= WP_ALLOW;
            if (START && READY) begin
               READY <= 1'b0;
               op_q <= OP;
               col_q <= COLUMN;
               row_q <= ROW;
               acnt_q <= 3'd0;
               bcnt_q <= 12'h000;
               tcnt_q <= 4'h0;
               phase_q <= 1'b0;
               CE_N <= 1'b0;
               CLE <= 1'b1;
               ALE <= 1'b0;
               IO_OE <= 1'b1;
               IO_OUT <= first_cmd(OP);
               WE_N <= 1'b0;
               state_q <= S_CMD1;
            end
         end
         S_CMD1, S_ADDR, S_DATA, S_CMD2: begin
            if (tcnt_q != STROBE_CYC - 4'd1) begin
               tcnt_q <= tcnt_q + 4'd1;
            end else begin
               tcnt_q <= 4'h0;
               phase_q <= ~phase_q;
               if (!phase_q) begin
                  WE_N <= 1'b1;
               end else begin
                  // pick the next byte
                  WE_N <= 1'b0;
                  CLE <= 1'b0;
                  ALE <= 1'b0;
                  if (state_q == S_CMD1 || (state_q == S_ADDR && acnt_q != 3'd0)) begin
                     if ((op_q == `NBI_OP_ERASE && state_q == S_ADDR && acnt_q == 3'd3)
                        || acnt_q == `NBI_ADDR_CYCLES) begin
                        if (op_q == `NBI_OP_PROG) begin
                           CLE <= 1'b0;
                           IO_OUT <= WDATA;
                           WDATA_TAKE <= 1'b1;
                           bcnt_q <= 12'h001;
                           state_q <= S_DATA;
                        end else begin
                           CLE <= 1'b1;
                           IO_OUT <= second_cmd(op_q);
                           state_q <= S_CMD2;
                        end
                     end else begin
                        ALE <= 1'b1;
                        // erase sends only the three row bytes
                        IO_OUT <= addr_byte((op_q == `NBI_OP_ERASE) ? acnt_q + 3'd2 : acnt_q,
                                            col_q, row_q);
                        acnt_q <= acnt_q + 3'd1;
                        state_q <= S_ADDR;
                     end
                  end else if (state_q == S_DATA && bcnt_q != `NBI_PAGE_BYTES - col_q) begin
                     IO_OUT <= WDATA;
                     WDATA_TAKE <= 1'b1;
                     bcnt_q <= bcnt_q + 12'h001;
                  end else if (state_q == S_DATA) begin
                     CLE <= 1'b1;
                     IO_OUT <= second_cmd(op_q);
                     state_q <= S_CMD2;
                  end else begin
                     WE_N <= 1'b1;
                     IO_OE <= 1'b0;
                     wcnt_q <= 6'h00;
                     state_q <= S_WAIT;
                  end
               end
            end
         end
         S_WAIT: begin
            // let busy assert before sampling it
            if (wcnt_q != BUSY_WAIT_CYC) begin
               wcnt_q <= wcnt_q + 6'h01;
            end else begin
               state_q <= S_BUSY;
            end
         end
         S_BUSY: begin
            if (rb_s2_q) begin
               if (op_q == `NBI_OP_READ) begin
                  RE_N <= 1'b0;
                  bcnt_q <= 12'h000;
                  tcnt_q <= 4'h0;
                  phase_q <= 1'b0;
                  state_q <= S_READ;
               end else begin
                  state_q <= S_DONE;
               end
            end
         end
         S_READ: begin
            if (tcnt_q != STROBE_CYC + 4'd2) begin
               tcnt_q <= tcnt_q + 4'd1;
               if (tcnt_q == STROBE_CYC - 4'd1) begin
                  RE_N <= 1'b1;
               end
            end else begin
               // synchronised sample of the byte driven since the falling edge
               tcnt_q <= 4'h0;
               RDATA <= io_s2_q;
               RDATA_VALID <= 1'b1;
               bcnt_q <= bcnt_q + 12'h001;
               if (bcnt_q == `NBI_PAGE_BYTES - col_q - 12'h001) begin
                  state_q <= S_DONE;
               end else begin
                  RE_N <= 1'b0;
               end
            end
         end
         S_DONE: begin
            CE_N <= 1'b1;
            DONE <= 1'b1;
            state_q <= S_IDLE;
         end
         default: state_q <= S_IDLE;
      endcase
   end
end

endmodule
`default_nettype wire

//--- tb/nbi_flash_model.sv
// behavioural flash device on the nand bus
`timescale 1ns/1ps
`default_nettype none
`include "nbi_regs.vh"
module nbi_flash_model #(
   parameter int READ_NS = 400,
   parameter int WORK_NS = 2500,
   parameter int READ_ACCESS_DELAY = 8
) (
   // control pins
   input wire logic ce_n,
   input wire logic cle,
   input wire logic ale,
   input wire logic we_n,
   input wire logic re_n,
   input wire logic wp_n,
   // data bus
   input wire logic [7:0] io,
   output logic [7:0] d_out,
   output logic d_en,
   // status, driven low while busy and high when ready
   output logic rb_n
);
   logic [7:0] pg [0:2175];
   logic [7:0] adr [0:4];
   logic [7:0] cmd_q = 8'h00;
   logic [11:0] col = 12'h000;
   logic [16:0] row;
   logic plane;
   logic [7:0] n_prog = 8'h00;
   logic [7:0] n_erase = 8'h00;
   int acnt = 0;
   int busy_ns;
   event go;
   initial begin
      for (int i = 0; i < 2176; i++) pg[i] = i[7:0] ^ 8'ha5;
      d_out = 8'h00;
      d_en = 1'b0;
      rb_n = 1'b1;
   end
   always @(posedge we_n) begin
      if (!ce_n && cle) begin
         cmd_q = io;
         acnt = (io == `NBI_CMD_ERASE_SETUP) ? 2 : 0;
         busy_ns = (io == `NBI_CMD_READ_CONFIRM) ? READ_NS : WORK_NS;
         if (io == `NBI_CMD_READ_CONFIRM) ->go;
         if (wp_n && io == `NBI_CMD_PROG_CONFIRM) n_prog = n_prog + 8'h01;
         if (wp_n && io == `NBI_CMD_ERASE_CONFIRM) n_erase = n_erase + 8'h01;
         if (wp_n && (io == `NBI_CMD_PROG_CONFIRM || io == `NBI_CMD_ERASE_CONFIRM)) ->go;
      end else if (!ce_n && ale) begin
         if (acnt < 5) adr[acnt] = io;
         acnt = acnt + 1;
         col = {adr[1][3:0], adr[0]};
         row = {adr[4][0], adr[3], adr[2]};
         plane = adr[2][6];
      end else if (!ce_n) begin
         pg[col] = io;
         col = col + 12'h001;
      end
   end
   always @(go) begin
      #50 rb_n = 1'b0;
      #(busy_ns) rb_n = 1'b1;
   end
   always @(negedge re_n) begin
      if (!ce_n) begin
         #(READ_ACCESS_DELAY) d_out = pg[col];
         d_en = 1'b1;
         col = col + 12'h001;
      end
   end
   always @(posedge ce_n) begin
      d_en = 1'b0;
      d_out = ~d_out;
   end
endmodule
`default_nettype wire

//--- tb/nbi_host_properties.sv
// concurrent checks on the host controller pins
`timescale 1ns/1ps
`default_nettype none
`include "nbi_regs.vh"
module nbi_host_props (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // user side
   input wire logic START,
   input wire logic [1:0] OP,
   input wire logic WP_ALLOW,
   input wire logic READY,
   input wire logic DONE,
   input wire logic RDATA_VALID,
   // nand pins
   input wire logic CE_N,
   input wire logic CLE,
   input wire logic ALE,
   input wire logic WE_N,
   input wire logic RE_N,
   input wire logic WP_N,
   input wire logic [7:0] IO_OUT,
   input wire logic IO_OE,
   input wire logic RB_N
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   logic [2:0] acnt_q;
   logic [1:0] op_q;
   logic ers;
   assign ers = (op_q == `NBI_OP_ERASE);
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         acnt_q <= 3'h0;
         op_q <= 2'h0;
      end else begin
         if (READY && START) op_q <= OP;
         if (CLE) acnt_q <= 3'h0;
         else if (ALE && $rose(WE_N)) acnt_q <= acnt_q + 3'h1;
      end
   end
   sequence s_we_pulse;
      !WE_N ##1 WE_N ##1 WE_N;
   endsequence
   property p_we_strobe;
      $fell(WE_N) |-> ##1 s_we_pulse;
   endproperty
   a_we_strobe: assert property (p_we_strobe) else $error("strobe width");
   property p_we_data;
      $rose(WE_N) |-> IO_OE && $stable(IO_OUT) && $stable({CLE, ALE});
   endproperty
   a_we_data: assert property (p_we_data) else $error("bus moved");
   property p_idle;
      READY |-> CE_N && !IO_OE;
   endproperty
   a_idle: assert property (p_idle) else $error("idle pins");
   property p_excl;
      !(CLE && ALE) && (RE_N || WE_N);
   endproperty
   a_excl: assert property (p_excl) else $error("cycle kinds mixed");
   property p_done;
      DONE |-> CE_N ##1 READY;
   endproperty
   a_done: assert property (p_done) else $error("end of operation");
   property p_wp;
      READY && $past(READY) |-> WP_N == $past(WP_ALLOW);
   endproperty
   a_wp: assert property (p_wp) else $error("protect level");
   property p_unused;
      ALE && !WE_N |-> (acnt_q != 3'h1 || ers || IO_OUT[7:4] == 4'h0)
         && (acnt_q != (ers ? 3'h2 : 3'h4) || IO_OUT[7:1] == 7'h00);
   endproperty
   a_unused: assert property (p_unused) else $error("unused bits");
   property p_addr_count;
      ALE && !WE_N |-> acnt_q < (ers ? 3'h3 : 3'h5);
   endproperty
   a_addr_count: assert property (p_addr_count) else $error("address bytes");
   property p_cmd;
      CLE && !WE_N |-> IO_OUT inside {8'h00, 8'h30, 8'h80, 8'h10, 8'h60, 8'hd0};
   endproperty
   a_cmd: assert property (p_cmd) else $error("command code");
   property p_rvalid;
      $fell(RE_N) |-> ##[1:8] RDATA_VALID;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read byte");
   property p_ready_rb;
      $fell(RE_N) |-> $past(RB_N) && $past(RB_N, 2);
   endproperty
   a_ready_rb: assert property (p_ready_rb) else $error("read while busy");
endmodule
bind nbi_host nbi_host_props u_props (
   .CLOCK, .RST, .START, .OP, .WP_ALLOW, .READY, .DONE, .RDATA_VALID,
   .CE_N, .CLE, .ALE, .WE_N, .RE_N, .WP_N, .IO_OUT, .IO_OE, .RB_N
);
`default_nettype wire

//--- tb/tb_nbi_host.sv
// self-checking bench for the nand bus host controller
`timescale 1ns/1ps
`default_nettype none
`include "nbi_regs.vh"
module tb_nbi_host;
   logic CLOCK, RST, START, WP_ALLOW, READY, DONE, WDATA_TAKE, RDATA_VALID;
   logic CE_N, CLE, ALE, WE_N, RE_N, WP_N, IO_OE, RB_N, d_en;
   logic [1:0] OP;
   logic [11:0] COLUMN;
   logic [16:0] ROW;
   logic [7:0] RDATA, IO_OUT, IO_IN, d_out;
   logic [7:0] WDATA = 8'h3c;
   logic [7:0] rq [$];
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   assign IO_IN = IO_OE ? (d_en ? 8'hxx : IO_OUT) : d_out;
   nbi_host dut (.CLOCK, .RST, .START, .OP, .COLUMN, .ROW, .WP_ALLOW, .READY, .DONE,
      .WDATA, .WDATA_TAKE, .RDATA, .RDATA_VALID, .CE_N, .CLE, .ALE, .WE_N, .RE_N,
      .WP_N, .IO_OUT, .IO_OE, .IO_IN, .RB_N);
   nbi_flash_model m (.ce_n(CE_N), .cle(CLE), .ale(ALE), .we_n(WE_N), .re_n(RE_N),
      .wp_n(WP_N), .io(IO_IN), .d_out(d_out), .d_en(d_en), .rb_n(RB_N));
   initial begin
      CLOCK = 1'b0;
      forever #5 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end
   always @(negedge CLOCK) begin
      if (RDATA_VALID === 1'b1) rq.push_back(RDATA);
      if (WDATA_TAKE === 1'b1) WDATA = WDATA + 8'h01;
   end
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic run_op(input logic [1:0] op, input logic [11:0] col,
      input logic [16:0] row, input logic wp);
      int k;
      k = 0;
      while (READY !== 1'b1 && k < 100) begin
         @(negedge CLOCK);
         k++;
      end
      OP = op;
      COLUMN = col;
      ROW = row;
      WP_ALLOW = wp;
      repeat (2) @(negedge CLOCK);
      rq.delete();
      START = 1'b1;
      @(negedge CLOCK);
      START = 1'b0;
      k = 0;
      while (DONE !== 1'b1 && k < 5000) begin
         @(negedge CLOCK);
         k++;
      end
      chk({16'h0000, DONE}, 17'h00001);
   endtask
   task automatic t_read(input logic [11:0] col, input logic [16:0] row,
      input logic [7:0] base, input logic fresh);
      run_op(`NBI_OP_READ, col, row, 1'b1);
      chk(m.row, row);
      chk({16'h0000, m.plane}, {16'h0000, row[6]});
      chk(17'(rq.size()), {5'h00, `NBI_PAGE_BYTES - col});
      foreach (rq[i])
         chk({9'h000, rq[i]}, {9'h000, fresh ? (col[7:0] + i[7:0]) ^ 8'ha5 : base + i[7:0]});
   endtask
   task automatic t_write();
      logic [7:0] wb, np, ne;
      for (int w = 1; w >= 0; w--) begin
         wb = WDATA;
         np = m.n_prog;
         ne = m.n_erase;
         run_op(`NBI_OP_PROG, 12'd2172, 17'h0a5b4, w[0]);
         chk({9'h000, m.n_prog}, {9'h000, np + 8'(w)});
         chk({9'h000, WDATA}, {9'h000, wb + 8'h04});
         if (w == 1) t_read(12'd2172, 17'h0a5b4, wb, 1'b0);
         run_op(`NBI_OP_ERASE, 12'h000, 17'h1ffc0 - 17'(w), w[0]);
         chk(m.row, 17'h1ffc0 - 17'(w));
         chk({9'h000, m.n_erase}, {9'h000, ne + 8'(w)});
      end
   endtask
   initial begin
      RST = 1'b1;
      START = 1'b0;
      OP = 2'h0;
      COLUMN = 12'h000;
      ROW = 17'h00000;
      WP_ALLOW = 1'b0;
      repeat (16) @(negedge CLOCK);
      RST = 1'b0;
      repeat (2) @(negedge CLOCK);
      chk({14'h0000, READY, CE_N, IO_OE}, 17'h00006);
      t_read(12'd2173, 17'h12345, 8'h00, 1'b1);
      t_write();
      wrap_up();
   end
endmodule
`default_nettype wire
